// ---- shared/gcl_defs.vh ----
// Constants for the gauge configuration and lifetime log block.
// Assumes a 100 MHz core clock and a host that writes registers directly.
// Behaviour
// RL1 - Logging runs only while gauging enabled
// RL2 - Logging needs enable and nonzero interval
// RL3 - Volatile table tracks every new extreme
// RL4 - Update only if extreme beats resolution
// RL5 - Update copies whole volatile table
// RL6 - Window of interval seconds, write at end
// RL7 - In-window extremes join; next opens window
// RL8 - Locked: block 4, lifetime data only
// RL9 - Unlocked: subclass 59 data, 66 resolutions
// RL10 - Unlocked lifetime writes apply after reset
// RL11 - Status bit15 pin active, bit7 armed
// RL12 - 0x0013 arms, 0x0014 disarms, auto-arm arms
// RL13 - Shutdown level only armed and hibernating
// RL14 - Pull-up and polarity select pin levels
// RL15 - Pin floats at reset; pull-up after reset
// RL16 - Auto-arm: assert low-V hibernate, negate wake
// RL17 - Pack word at subclass 64 offset 0; code keeps it at register index 0 and resets it to the default
// RL18 - High byte fields and defaults
// RL19 - Low byte bits 6..4 default one
// RL20 - Bit0 picks thermistor, else internal sensor
// RL21 - Over-temp flag set after delay, clears
// RL22 - Zero delay disables over-temp flag
// RL23 - Low-V hibernate releases pin to shutdown
// RL24 - Delay timer restarts on lapse
// RL25 - Log write atomic per window
`ifndef GCL_DEFS_VH
`define GCL_DEFS_VH

// Register word indexes
`define GCL_A_PCFG 4'h0
`define GCL_A_CSTAT 4'h1
`define GCL_A_CMD 4'h2
`define GCL_A_ACC 4'h3
`define GCL_A_LTIDX 4'h4
`define GCL_A_LTDAT 4'h5
`define GCL_A_OTLIM 4'h6
`define GCL_A_OTREL 4'h7
`define GCL_A_OTDLY 4'h8
`define GCL_A_CHGTH 4'h9

// Commands
`define GCL_CMD_ARM 16'h0013
`define GCL_CMD_DISARM 16'h0014
`define GCL_CMD_GAUGE 16'h0021

// Access selectors
`define GCL_SC_LIFE 8'h3B
`define GCL_SC_RES 8'h42
`define GCL_SC_PCFG 8'h40
`define GCL_BLK_LIFE 8'h04
`define GCL_ACC_UNLK 15

// Pack configuration fields and default
`define GCL_PCFG_DEF 16'h0177
`define GCL_PC_PU 3
`define GCL_PC_POL 2
`define GCL_PC_ARM 1
`define GCL_PC_EXT_THERMISTOR_SEL 0

// Status bits
`define GCL_ST_PIN 15
`define GCL_ST_ARMED 7
`define GCL_ST_WIN 1
`define GCL_ST_GAUGE 0

// Lifetime table and resolution indexes
`define GCL_LT_N 6
`define GCL_LT_LAST 3'h5
`define GCL_RES_LAST 3'h3
`define GCL_RES_T 0
`define GCL_RES_V 1
`define GCL_RES_I 2
`define GCL_RES_UPD 3

// Timing
`define GCL_CLK_NS 10
`define GCL_SEC_NS 1000000000

`endif

// ---- rtl/gcl_ovt.v ----
// Charge over-temperature qualifier with a seconds delay timer.
// Assumes a one-cycle seconds tick and measurement strobe from the top.
`timescale 1ns/10ps
module gcl_ovt (
  input wire core_clk_i,         // Core clock
  input wire rst_i,              // Async reset, active high
  input wire sec_tick_i,         // One pulse per second
  input wire sample_i,           // New measurement strobe
  input wire [15:0] temp_i,      // Selected temperature
  input wire [15:0] curr_i,      // Signed average current
  input wire [15:0] limit_i,     // Over-temp limit
  input wire [15:0] release_i,   // Recovery temperature
  input wire [15:0] delay_i,     // Delay in seconds
  input wire [15:0] chg_th_i,    // Charge current threshold
  output reg flag_o              // Charge over-temp flag
);

  // ==========================================
  // Qualification and timer
  reg [15:0] secs;
  reg qual;
  wire hot = $signed(temp_i) >= $signed(limit_i);
  wire chg = $signed(curr_i) > $signed(chg_th_i);

  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      secs <= 16'h0000;
      qual <= 1'b0;
      flag_o <= 1'b0;
    end else begin
      if (sample_i) begin
        qual <= hot & chg;
      end
      // A lapse before expiry drops the partial count
      if (!qual || (sample_i && !(hot & chg))) begin
        secs <= 16'h0000; // RL24
      end else if (sec_tick_i && secs != delay_i) begin
        secs <= secs + 16'h0001; // RL21
      end
      if (sample_i && $signed(temp_i) <= $signed(release_i)) begin
        flag_o <= 1'b0; // RL21
      end else if (qual && delay_i != 16'h0000 && secs == delay_i) begin
        flag_o <= 1'b1; // RL22
      end
    end
  end

endmodule // gcl_ovt

// ---- rtl/gcl_top.v ----
// Gauge configuration, power-off pin and lifetime max/min logger.
// Assumes a host writing registers over a strobe port and a gauge core
// that supplies measurements and the hibernate state.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/10ps
`include "gcl_defs.vh"
module gcl_top #(
  parameter SEC_CYC = `GCL_SEC_NS / `GCL_CLK_NS
) (
  input wire core_clk_i,          // 100 MHz clock
  input wire rst_i,               // Power-on reset, async, active high
  input wire [3:0] addr_i,        // Register word index
  input wire [15:0] wr_data_i,    // Write data
  input wire wr_i,                // Write strobe
  input wire rd_i,                // Read strobe
  output reg [15:0] rd_data_o,    // Read data, cycle after strobe
  input wire sample_i,            // New measurement strobe
  input wire [15:0] temp_ext_i,   // Thermistor temperature
  input wire [15:0] temp_int_i,   // On-chip sensor temperature
  input wire [15:0] volt_i,       // Cell voltage
  input wire [15:0] curr_i,       // Signed average current
  input wire hibernate_i,         // Core is in hibernate
  input wire hib_low_v_i,         // Hibernate was entered on low voltage
  input wire power_off_i,         // Pin level seen
  output reg power_off_o,         // Pin drive value
  output reg power_off_oe_o,      // Pin driven when high
  output reg ext_thermistor_sel_o, // Thermistor chosen
  output reg [15:0] temp_o,       // Selected temperature
  output reg nvm_commit_o,        // Pulse: log table written
  output wire charge_overtemp_flag_o // Charge over-temp flag
);

  // ==========================================
  // Helpers
  // Two guard bits keep the signed difference from overflowing
  function exceed;
    input [15:0] a;
    input [15:0] b;
    input [15:0] r;
    reg signed [17:0] d;
    begin
      d = $signed({{2{a[15]}}, a}) - $signed({{2{b[15]}}, b});
      exceed = d > $signed({2'b00, r});
    end
  endfunction

  function [15:0] smax;
    input [15:0] a;
    input [15:0] b;
    begin
      smax = ($signed(a) > $signed(b)) ? a : b;
    end
  endfunction

  // ==========================================
  // State
  reg [15:0] pack_configuration_word;
  reg armed;
  reg gauging_algorithm_on;
  reg [15:0] acc;
  reg [2:0] lt_idx;
  reg [15:0] charge_overtemp_limit;
  reg [15:0] charge_overtemp_release;
  reg [15:0] charge_overtemp_delay;
  reg [15:0] chg_th;
  reg ld_pend;
  reg pu_lat;
  reg pin_act;
  reg win_open;
  reg [31:0] win_cyc;
  reg [15:0] win_sec;
  reg [31:0] pre;
  reg sec_tick;
  // Nonvolatile storage (nv_tab, res_tab, pu_nv): deliberately not reset
  // Contents stay unknown until the host programs them
  reg [15:0] nv_tab [0:5];
  reg [15:0] res_tab [0:3];
  reg pu_nv;
  reg [15:0] ram_tab [0:5];
  integer i;
  // One loop index per process keeps every variable single-driven
  integer j;

  wire [7:0] nvm_block_select = acc[7:0];
  wire unlk = acc[`GCL_ACC_UNLK];
  wire sel_life_u = unlk && nvm_block_select == `GCL_SC_LIFE; // RL9
  wire sel_res = unlk && nvm_block_select == `GCL_SC_RES; // RL9
  wire sel_life_l = !unlk && nvm_block_select == `GCL_BLK_LIFE; // RL8
  wire lt_ok = lt_idx <= `GCL_LT_LAST;
  wire res_ok = lt_idx <= `GCL_RES_LAST;
  wire [15:0] log_min_interval = res_tab[`GCL_RES_UPD];
  wire log_on = gauging_algorithm_on &&
                log_min_interval != 16'h0000; // RL1 RL2
  wire poweroff_auto_arm = pack_configuration_word[`GCL_PC_ARM];
  wire poweroff_polarity = pack_configuration_word[`GCL_PC_POL];
  wire ext_sel = pack_configuration_word[`GCL_PC_EXT_THERMISTOR_SEL];
  wire [15:0] temp_now = ext_sel ? temp_ext_i : temp_int_i; // RL20
  wire [15:0] dsg = 16'h0000 - curr_i;
  wire [15:0] rt = res_tab[`GCL_RES_T];
  wire [15:0] rv = res_tab[`GCL_RES_V];
  wire [15:0] ri = res_tab[`GCL_RES_I];
  wire qual = exceed(ram_tab[0], nv_tab[0], rt) |
              exceed(nv_tab[1], ram_tab[1], rt) |
              exceed(ram_tab[2], nv_tab[2], rv) |
              exceed(nv_tab[3], ram_tab[3], rv) |
              exceed(ram_tab[4], nv_tab[4], ri) |
              exceed(ram_tab[5], nv_tab[5], ri); // RL4
  wire win_end = win_open && win_cyc == SEC_CYC - 1 &&
                 win_sec == log_min_interval - 16'h0001;
  wire wr_cmd = wr_i && addr_i == `GCL_A_CMD;
  wire wr_lt = wr_i && addr_i == `GCL_A_LTDAT;

  // ==========================================
  // Register writes
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pack_configuration_word <= `GCL_PCFG_DEF; // RL18 RL19
      gauging_algorithm_on <= 1'b0;
      acc <= 16'h0000;
      lt_idx <= 3'h0;
      charge_overtemp_limit <= 16'h0000;
      charge_overtemp_release <= 16'h0000;
      charge_overtemp_delay <= 16'h0000;
      chg_th <= 16'h0000;
    end else if (wr_i) begin
      case (addr_i)
        `GCL_A_PCFG: pack_configuration_word <= wr_data_i; // RL17
        `GCL_A_CMD: begin
          if (wr_data_i == `GCL_CMD_GAUGE) begin
            gauging_algorithm_on <= 1'b1; // RL1
          end
        end
        `GCL_A_ACC: acc <= wr_data_i;
        `GCL_A_LTIDX: lt_idx <= wr_data_i[2:0];
        `GCL_A_OTLIM: charge_overtemp_limit <= wr_data_i;
        `GCL_A_OTREL: charge_overtemp_release <= wr_data_i;
        `GCL_A_OTDLY: charge_overtemp_delay <= wr_data_i;
        `GCL_A_CHGTH: chg_th <= wr_data_i;
        default: ;
      endcase
    end
  end

  // ==========================================
  // Nonvolatile model: a table write and a commit land in one cycle,
  // so a reset never leaves a half-copied table behind
  always @(posedge core_clk_i) begin
    if (win_end) begin
      for (i = 0; i < `GCL_LT_N; i = i + 1) begin
        nv_tab[i] <= ram_tab[i]; // RL5 RL25
      end
    end else if (wr_lt && lt_ok && (sel_life_u || sel_life_l)) begin
      nv_tab[lt_idx] <= wr_data_i; // RL8 RL9
    end
    if (wr_lt && res_ok && sel_res) begin
      res_tab[lt_idx[1:0]] <= wr_data_i; // RL9
    end
    if (wr_i && addr_i == `GCL_A_PCFG) begin
      pu_nv <= wr_data_i[`GCL_PC_PU];
    end
  end

  // ==========================================
  // Volatile max/min table
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ld_pend <= 1'b1;
      for (j = 0; j < `GCL_LT_N; j = j + 1) begin
        ram_tab[j] <= 16'h0000;
      end
    end else begin
      ld_pend <= 1'b0;
      if (ld_pend) begin
        // Unlocked writes reach the live table only through here
        for (j = 0; j < `GCL_LT_N; j = j + 1) begin
          ram_tab[j] <= nv_tab[j]; // RL10
        end
      end else if (wr_lt && lt_ok && sel_life_l) begin
        ram_tab[lt_idx] <= wr_data_i; // RL8
      end else if (sample_i && log_on) begin
        ram_tab[0] <= smax(ram_tab[0], temp_now); // RL3
        ram_tab[1] <= smax(ram_tab[1], temp_now) == temp_now ?
                      ram_tab[1] : temp_now; // RL3
        ram_tab[2] <= smax(ram_tab[2], volt_i); // RL3
        ram_tab[3] <= smax(ram_tab[3], volt_i) == volt_i ?
                      ram_tab[3] : volt_i; // RL3
        ram_tab[4] <= smax(ram_tab[4], curr_i); // RL3
        ram_tab[5] <= smax(ram_tab[5], dsg); // RL3
      end
    end
  end

  // ==========================================
  // Update window
  // Limitation: clearing the interval while a window is open stretches
  // that window, so change it only while logging is off
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      win_open <= 1'b0;
      win_cyc <= 32'h00000000;
      win_sec <= 16'h0000;
      nvm_commit_o <= 1'b0;
    end else begin
      nvm_commit_o <= win_end; // RL6
      if (win_end) begin
        win_open <= 1'b0; // RL7
      end else if (!win_open && log_on && qual) begin
        // Extremes arriving later just ride along until the end
        win_open <= 1'b1; // RL6 RL7
        win_cyc <= 32'h00000000;
        win_sec <= 16'h0000;
      end else if (win_open) begin
        if (win_cyc == SEC_CYC - 1) begin
          win_cyc <= 32'h00000000;
          win_sec <= win_sec + 16'h0001; // RL6
        end else begin
          win_cyc <= win_cyc + 32'h00000001;
        end
      end
    end
  end

  // ==========================================
  // Seconds tick for the over-temperature timer
  // Free running, so the first counted second may be short
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pre <= 32'h00000000;
      sec_tick <= 1'b0;
    end else begin
      sec_tick <= pre == SEC_CYC - 1;
      pre <= (pre == SEC_CYC - 1) ? 32'h00000000 : pre + 32'h00000001;
    end
  end

  gcl_ovt u_ovt (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .sec_tick_i(sec_tick),
    .sample_i(sample_i),
    .temp_i(temp_now),
    .curr_i(curr_i),
    .limit_i(charge_overtemp_limit),
    .release_i(charge_overtemp_release),
    .delay_i(charge_overtemp_delay),
    .chg_th_i(chg_th),
    .flag_o(charge_overtemp_flag_o)
  );

  // ==========================================
  // Power-off pin
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      armed <= 1'b0; // RL11
      pin_act <= 1'b0; // RL11
      pu_lat <= 1'b0;
      power_off_o <= 1'b0;
      power_off_oe_o <= 1'b0; // RL15
      ext_thermistor_sel_o <= 1'b1;
      temp_o <= 16'h0000;
    end else begin
      ext_thermistor_sel_o <= ext_sel; // RL20
      temp_o <= temp_now;
      // The pull-up choice comes from the stored copy at reset only, so a
      // pack word rewrite cannot change whether the pin is driven at all times
      if (ld_pend) begin
        pu_lat <= pu_nv; // RL15
      end
      if (poweroff_auto_arm || (wr_cmd && wr_data_i == `GCL_CMD_ARM)) begin
        armed <= 1'b1; // RL12
      end else if (wr_cmd && wr_data_i == `GCL_CMD_DISARM) begin
        armed <= 1'b0; // RL12
      end
      // Only a low-voltage hibernate may cut power
      pin_act <= armed && hibernate_i && hib_low_v_i; // RL13 RL16 RL23
      if (!ld_pend) begin
        case ({pu_lat, poweroff_polarity})
          2'b00: begin
            power_off_o <= 1'b0;
            power_off_oe_o <= pin_act; // RL14
          end
          2'b01: begin
            power_off_o <= 1'b0;
            power_off_oe_o <= !pin_act; // RL14
          end
          2'b10: begin
            power_off_o <= !pin_act;
            power_off_oe_o <= 1'b1; // RL14
          end
          2'b11: begin
            power_off_o <= pin_act;
            power_off_oe_o <= 1'b1; // RL14
          end
          default: begin
            power_off_o <= 1'b0;
            power_off_oe_o <= 1'b0;
          end
        endcase
      end
    end
  end

  // ==========================================
  // Register reads
  // Reads have no side effects on any state
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_o <= 16'h0000;
    end else if (rd_i) begin
      case (addr_i)
        `GCL_A_PCFG: rd_data_o <= pack_configuration_word;
        `GCL_A_CSTAT: begin
          rd_data_o <= 16'h0000;
          rd_data_o[`GCL_ST_PIN] <= pin_act; // RL11
          rd_data_o[`GCL_ST_ARMED] <= armed; // RL11
          rd_data_o[`GCL_ST_WIN] <= win_open;
          rd_data_o[`GCL_ST_GAUGE] <= gauging_algorithm_on;
        end
        `GCL_A_ACC: rd_data_o <= acc;
        `GCL_A_LTIDX: rd_data_o <= {13'h0000, lt_idx};
        `GCL_A_LTDAT: begin
          if (lt_ok && (sel_life_u || sel_life_l)) begin
            rd_data_o <= nv_tab[lt_idx]; // RL8 RL9
          end else if (res_ok && sel_res) begin
            rd_data_o <= res_tab[lt_idx[1:0]]; // RL9
          end else begin
            rd_data_o <= 16'h0000;
          end
        end
        `GCL_A_OTLIM: rd_data_o <= charge_overtemp_limit;
        `GCL_A_OTREL: rd_data_o <= charge_overtemp_release;
        `GCL_A_OTDLY: rd_data_o <= charge_overtemp_delay;
        `GCL_A_CHGTH: rd_data_o <= chg_th;
        default: rd_data_o <= 16'h0000;
      endcase
    end
  end

endmodule // gcl_top

// ---- tb/gcl_pin_model.sv ----
// Board side of the power-off pin: a resistor and the shutdown circuit.
// Assumes the block drives the pin from a core_clk_i register.
`timescale 1ns/10ps
module gcl_pin_model #(
  parameter PULL = 1'b1
) (
  input wire core_clk_i, // Core clock
  input wire drive_i,    // Value driven by the block
  input wire oe_i,       // Block drives the pin when high
  output reg level_o     // Wire level fed back to the block
);
  // ==========================================
  // Pin level
  // A released pin settles to the resistor level, never to the last drive
  always @(posedge core_clk_i) begin
    level_o <= oe_i ? drive_i : PULL;
  end
endmodule // gcl_pin_model

// ---- tb/gcl_top_sva.sv ----
// Checker on the ports of the gauge configuration block.
// Assumes the pack word is never rewritten next to a measurement strobe.
`timescale 1ns/10ps
module gcl_chk #(
  parameter SEC_CYC = 20
) (
  input wire core_clk_i,             // Core clock
  input wire rst_i,                  // Async reset
  input wire [3:0] addr_i,           // Register index
  input wire [15:0] wr_data_i,       // Write data
  input wire wr_i,                   // Write strobe
  input wire rd_i,                   // Read strobe
  input wire [15:0] rd_data_o,       // Read data
  input wire sample_i,               // Measurement strobe
  input wire [15:0] temp_ext_i,      // Thermistor temperature
  input wire [15:0] temp_int_i,      // On-chip temperature
  input wire [15:0] temp_o,          // Selected temperature
  input wire ext_thermistor_sel_o,   // Thermistor chosen
  input wire power_off_oe_o,         // Pin enable
  input wire nvm_commit_o,           // Log write pulse
  input wire charge_overtemp_flag_o  // Over-temp flag
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================
  // Cycles since the last log write
  reg [31:0] gap;
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) gap <= 32'h00000000;
    else if (nvm_commit_o) gap <= 32'h00000000;
    else if (gap != 32'hFFFFFFFF) gap <= gap + 32'h00000001;
  end
  sequence s_float;
    !power_off_oe_o ##1 !power_off_oe_o;
  endsequence
  // ==========================================
  // Assertions
  a_unmapped_read: assert property (rd_i && addr_i > 4'h9 |=>
    rd_data_o == 16'h0000) else $error("unmapped read not zero");
  a_commit_pulse: assert property (nvm_commit_o |=> !nvm_commit_o)
    else $error("log write pulse too long");
  a_commit_gap: assert property (nvm_commit_o |-> gap >= SEC_CYC)
    else $error("log writes too close");
  a_temp_ext: assert property (sample_i && ext_thermistor_sel_o |=>
    temp_o == $past(temp_ext_i)) else $error("thermistor not used");
  a_temp_int: assert property (sample_i && !ext_thermistor_sel_o |=>
    temp_o == $past(temp_int_i)) else $error("internal sensor not used");
  a_reset_float: assert property ($fell(rst_i) |-> s_float)
    else $error("pin driven after reset");
  a_reset_defaults: assert property ($fell(rst_i) |->
    ext_thermistor_sel_o && !nvm_commit_o && !charge_overtemp_flag_o)
    else $error("bad reset values");
  a_sel_follows: assert property (wr_i && addr_i == 4'h0 |-> ##2
    ext_thermistor_sel_o == $past(wr_data_i[0], 2))
    else $error("sensor select not updated");
endmodule // gcl_chk
bind gcl_top gcl_chk #(.SEC_CYC(SEC_CYC)) gcl_chk_inst (.core_clk_i, .rst_i,
  .addr_i, .wr_data_i, .wr_i, .rd_i, .rd_data_o, .sample_i, .temp_ext_i,
  .temp_int_i, .temp_o, .ext_thermistor_sel_o, .power_off_oe_o,
  .nvm_commit_o, .charge_overtemp_flag_o);

// ---- tb/tb.sv ----
// Self-checking bench for the gauge configuration block.
// Assumes one-second windows shortened to SEC cycles.
`timescale 1ns/10ps
module tb;
  localparam SEC = 20;
  localparam [7:0] NORM = 8'hB9;
  localparam [7:0] SHUT = 8'hE6;
  localparam [95:0] NVI = {16'h0000, 16'h0000, 16'h0BB8, 16'h0BB8,
    16'h0064, 16'h0064};
  localparam [63:0] RESV = {16'h0001, 16'h000A, 16'h000A, 16'h0005};
  reg core_clk_i, rst_i, wr_i, rd_i, sample_i, hibernate_i, hib_low_v_i;
  reg [3:0] addr_i;
  reg [15:0] wr_data_i, temp_ext_i, temp_int_i, volt_i, curr_i;
  wire [15:0] rd_data_o, temp_o;
  wire power_off_i, power_off_o, power_off_oe_o, ext_thermistor_sel_o;
  wire nvm_commit_o, charge_overtemp_flag_o;
  integer fails, num_checks;
  gcl_top #(.SEC_CYC(SEC)) gcl_top_inst (.core_clk_i, .rst_i, .addr_i,
    .wr_data_i, .wr_i, .rd_i, .rd_data_o, .sample_i, .temp_ext_i,
    .temp_int_i, .volt_i, .curr_i, .hibernate_i, .hib_low_v_i,
    .power_off_i, .power_off_o, .power_off_oe_o, .ext_thermistor_sel_o,
    .temp_o, .nvm_commit_o, .charge_overtemp_flag_o);
  gcl_pin_model gcl_pin_model_inst (.core_clk_i, .drive_i(power_off_o),
    .oe_i(power_off_oe_o), .level_o(power_off_i));
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  // ==========================================
  // Shared tasks
  task chk(input [15:0] got, input [15:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task final_report;
    begin
      $display("Checks %0d, mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  task rst_pulse;
    begin
      rst_i <= 1'b1;
      repeat (6) @(posedge core_clk_i);
      rst_i <= 1'b0;
      @(posedge core_clk_i);
    end
  endtask
  // An idle cycle after each strobe keeps one assignment per time step
  task wr(input [3:0] a, input [15:0] d);
    begin
      addr_i <= a;
      wr_data_i <= d;
      wr_i <= 1'b1;
      @(posedge core_clk_i);
      wr_i <= 1'b0;
      @(posedge core_clk_i);
    end
  endtask
  task rd(input [3:0] a, input [15:0] exp);
    begin
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge core_clk_i);
      rd_i <= 1'b0;
      #1 chk(rd_data_o, exp);
      @(posedge core_clk_i);
    end
  endtask
  task smp(input [15:0] t, input [15:0] v, input [15:0] c);
    begin
      temp_ext_i <= t;
      temp_int_i <= t + 16'h0001;
      volt_i <= v;
      curr_i <= c;
      sample_i <= 1'b1;
      @(posedge core_clk_i);
      sample_i <= 1'b0;
      @(posedge core_clk_i);
    end
  endtask
  // Pin seen as {enable, wire level} once the three register stages settle
  task pin(input [1:0] exp);
    begin
      repeat (4) @(posedge core_clk_i);
      chk({14'h0000, power_off_oe_o, power_off_i}, {14'h0000, exp});
    end
  endtask
  task wait_commit(input integer lim, input must, output integer n);
    begin
      n = 0;
      while (n < lim && nvm_commit_o !== 1'b1) begin
        @(posedge core_clk_i);
        n = n + 1;
      end
      if (must && n == lim) begin
        fails = fails + 1;
        $display("Error at %0t: got %h expected %h", $time, n, lim);
        final_report;
      end
    end
  endtask
  // ==========================================
  // Scenarios
  task t_regs;
    begin
      rd(4'h0, 16'h0177);
      rd(4'h1, 16'h0080);
      wr(4'h0, 16'h0171);
      wr(4'h2, 16'h0014);
      rd(4'h1, 16'h0000);
      wr(4'h2, 16'h0013);
      wr(4'h1, 16'hFFFF);
      rd(4'h1, 16'h0080);
      wr(4'hC, 16'hFFFF);
      rd(4'hC, 16'h0000);
    end
  endtask
  task t_pin;
    integer e;
    begin
      for (e = 0; e < 4; e = e + 1) begin
        wr(4'h0, {12'h017, e[1:0], 2'b10});
        rst_pulse;
        wr(4'h0, {12'h017, e[1:0], 2'b10});
        pin(NORM[2*e+:2]);
        hibernate_i <= 1'b1;
        pin(NORM[2*e+:2]);
        hib_low_v_i <= 1'b1;
        pin(SHUT[2*e+:2]);
        rd(4'h1, 16'h8080);
        hibernate_i <= 1'b0;
        hib_low_v_i <= 1'b0;
        pin(NORM[2*e+:2]);
      end
      wr(4'h0, 16'h017C);
      wr(4'h2, 16'h0014);
      hibernate_i <= 1'b1;
      hib_low_v_i <= 1'b1;
      pin(NORM[7:6]);
      hibernate_i <= 1'b0;
      hib_low_v_i <= 1'b0;
      smp(16'h0030, 16'h0BB8, 16'h0000);
      chk({15'h0000, ext_thermistor_sel_o}, 16'h0000);
      chk(temp_o, 16'h0031);
    end
  endtask
  task t_life;
    integer i, n;
    begin
      wr(4'h3, 16'h8042);
      for (i = 0; i < 4; i = i + 1) begin
        wr(4'h4, i[15:0]);
        wr(4'h5, RESV[16*i+:16]);
      end
      wr(4'h3, 16'h803B);
      for (i = 0; i < 6; i = i + 1) begin
        wr(4'h4, i[15:0]);
        wr(4'h5, NVI[16*i+:16]);
      end
      rst_pulse;
      wr(4'h0, 16'h0171);
      smp(16'h012C, 16'h0BB8, 16'h0000);
      wait_commit(3 * SEC, 1'b0, n);
      chk(n[15:0], 16'(3 * SEC));
      wr(4'h2, 16'h0021);
      smp(16'h0067, 16'h0BBA, 16'h0000);
      wait_commit(3 * SEC, 1'b0, n);
      chk(n[15:0], 16'(3 * SEC));
      smp(16'h00C8, 16'h0BBA, 16'h0000);
      smp(16'h00D2, 16'h0BBA, 16'h0000);
      chk(temp_o, 16'h00D2);
      wait_commit(SEC + 6, 1'b1, n);
      chk({15'h0000, n >= SEC - 4}, 16'h0001);
      wr(4'h3, 16'h803B);
      wr(4'h4, 16'h0000);
      rd(4'h5, 16'h00D2);
      wr(4'h4, 16'h0002);
      rd(4'h5, 16'h0BBA);
      wr(4'h4, 16'h0001);
      rd(4'h5, 16'h0064);
      wr(4'h3, 16'h0004);
      wr(4'h4, 16'h0000);
      rd(4'h5, 16'h00D2);
      wr(4'h3, 16'h0042);
      rd(4'h5, 16'h0000);
    end
  endtask
  task t_ot;
    integer d;
    begin
      wr(4'h6, 16'h0032);
      wr(4'h7, 16'h0028);
      wr(4'h9, 16'h000A);
      for (d = 0; d < 4; d = d + 2) begin
        wr(4'h8, d[15:0]);
        repeat (40) smp(16'h003C, 16'h0BBA, 16'h0014);
        chk({15'h0000, charge_overtemp_flag_o}, d[15:0] >> 1);
      end
      smp(16'h0028, 16'h0BBA, 16'h0014);
      chk({15'h0000, charge_overtemp_flag_o}, 16'h0000);
    end
  endtask
  // ==========================================
  // Main sequence
  initial begin
    fails = 0;
    num_checks = 0;
    rst_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    sample_i = 1'b0;
    hibernate_i = 1'b0;
    hib_low_v_i = 1'b0;
    addr_i = 4'h0;
    wr_data_i = 16'h0000;
    temp_ext_i = 16'h0000;
    temp_int_i = 16'h0000;
    volt_i = 16'h0000;
    curr_i = 16'h0000;
    rst_pulse;
    t_regs;
    t_pin;
    t_life;
    t_ot;
    final_report;
  end
endmodule // tb
